// [rtl/cdac_pkg.sv]
package cdac_pkg;

	// apb register byte offsets
	localparam logic [7:0] CDAC_CTRL_OFS   = 8'h00;
	localparam logic [7:0] CDAC_STATE_OFS  = 8'h04;
	localparam logic [7:0] CDAC_IRQ_ST_OFS = 8'h08;
	localparam logic [7:0] CDAC_IRQ_MK_OFS = 8'h0C;
	localparam logic [7:0] CDAC_RAMP_OFS   = 8'h10;

	// control register fields
	localparam int CDAC_CTRL_RETRY_EN = 0;
	localparam logic [31:0] CDAC_CTRL_RST = 32'h0000_0001;

	// interrupt event bit positions
	localparam int CDAC_EV_FAULT   = 0;
	localparam int CDAC_EV_RECOVER = 1;
	localparam int CDAC_EV_PLAY    = 2;
	localparam int CDAC_EV_STOP    = 3;
	localparam int CDAC_EV_W       = 4;

	localparam logic [CDAC_EV_W-1:0] CDAC_MASK_RST = 4'h0;

	// timing
	localparam int CDAC_CLK_MHZ       = 100;
	localparam int CDAC_CAL_NS        = 2000;
	localparam int CDAC_CAL_CYC       = (CDAC_CAL_NS * CDAC_CLK_MHZ) / 1000;
	localparam int CDAC_RETRY_NS      = 1000;
	localparam int CDAC_RETRY_CYC     = (CDAC_RETRY_NS * CDAC_CLK_MHZ) / 1000;
	localparam int CDAC_RAMP_W        = 8;
	localparam logic [CDAC_RAMP_W-1:0] CDAC_RAMP_MAX = 8'hFF;
	localparam logic [CDAC_RAMP_W-1:0] CDAC_RAMP_MIN = 8'h00;
	localparam logic [15:0] CDAC_RAMP_DIV_RST = 16'h0004;
	localparam int CDAC_CNT_W         = 16;

	typedef enum logic [2:0] {
		CDAC_OFF   = 3'b000,
		CDAC_CAL   = 3'b001,
		CDAC_RUP   = 3'b010,
		CDAC_PLAY  = 3'b011,
		CDAC_RDN   = 3'b100,
		CDAC_RETRY = 3'b101
	} cdac_state_t;

	// raw pins from the host and the analog monitors
	typedef struct packed {
		logic       mute;
		logic       sleep;
		logic [1:0] gain_select;
	} cdac_pins_t;

	typedef struct packed {
		logic power_stage_uv;
		logic charge_pump_uv;
		logic analog_five_volt_uv;
		logic over_current;
		logic over_temp;
	} cdac_fault_t;

	// bridge outputs: pwm level plus enable per leg
	typedef struct packed {
		logic left_bridge_positive_output;
		logic left_bridge_negative_output;
		logic right_bridge_positive_output;
		logic right_bridge_negative_output;
	} cdac_bridge_t;

endpackage

// [rtl/cdac_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module cdac_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,    // clock
	input  wire logic         presetn, // async reset, low
	input  wire logic [W-1:0] d,       // asynchronous level
	output logic      [W-1:0] q        // synchronised level
);
	logic [W-1:0] meta_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule
`default_nettype wire

// [rtl/cdac_ctrl.sv]
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cdac_ctrl (
	input  wire logic                pclk,        // clock, 100 MHz
	input  wire logic                presetn,     // async reset, low
	input  wire logic                psel,        // apb select
	input  wire logic                penable,     // apb enable
	input  wire logic                pwrite,      // apb direction
	input  wire logic [7:0]          paddr,       // apb byte address
	input  wire logic [31:0]         pwdata,      // apb write data
	output logic      [31:0]         prdata,      // apb read data
	output logic                     pready,      // apb ready
	output logic                     pslverr,     // apb error
	input  wire cdac_pkg::cdac_pins_t  pins,      // raw host pins
	input  wire cdac_pkg::cdac_fault_t uv_fall,   // rail below falling threshold
	input  wire cdac_pkg::cdac_fault_t uv_rise,   // rail above rising threshold
	input  wire logic                cal_done,    // analog offset calibration done
	input  wire cdac_pkg::cdac_bridge_t pwm_in,   // modulator bridge drive
	output var cdac_pkg::cdac_bridge_t bridge_o,  // bridge output level
	output var cdac_pkg::cdac_bridge_t bridge_oe, // bridge output enable
	output logic                     status,      // not ready / fault flag
	output logic                     bias_en,     // internal bias enable
	output logic                     low_power,   // low quiescent mode
	output logic                     cal_start,   // offset calibration request
	output logic      [7:0]          offset_level,// dc offset ramp level
	output logic      [1:0]          gain_sel,    // applied gain setting
	output logic                     irq          // interrupt, high level
);
	import cdac_pkg::*;

	cdac_pins_t               pins_s;
	cdac_fault_t              fault_q;
	cdac_state_t              state_q, state_d;
	logic [CDAC_CNT_W-1:0]    cnt_q;
	logic [15:0]              ramp_div_q;
	logic [CDAC_RAMP_W-1:0]   ramp_q;
	logic [1:0]               gain_q;
	logic                     retry_en_q;
	logic [CDAC_EV_W-1:0]     ist_q, imask_q, ev;
	cdac_bridge_t             bridge_q;
	cdac_bridge_t             oe_q;

	cdac_sync #(.W(4)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pins),
		.q       (pins_s)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_fault
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					fault_q[gi] <= 1'b1;
				end else if (uv_fall[gi]) begin
					fault_q[gi] <= 1'b1;
				end else if (uv_rise[gi]) begin
					fault_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	wire any_fault = |fault_q;
	wire want_play = !pins_s.mute && !pins_s.sleep && !any_fault;
	wire ramp_tick = (ramp_div_q == 16'h0000);
	wire cnt_zero  = (cnt_q == '0);

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CDAC_OFF: begin
				if (want_play) begin
					state_d = CDAC_CAL;
				end
			end
			CDAC_CAL: begin
				if (any_fault) begin
					state_d = CDAC_RETRY;
				end else if (!want_play) begin
					state_d = CDAC_OFF;
				end else if (cal_done && cnt_zero) begin
					state_d = CDAC_RUP;
				end
			end
			CDAC_RUP: begin
				if (any_fault) begin
					state_d = CDAC_RETRY;
				end else if (!want_play) begin
					state_d = CDAC_RDN;
				end else if (ramp_q == CDAC_RAMP_MAX) begin
					state_d = CDAC_PLAY;
				end
			end
			CDAC_PLAY: begin
				if (any_fault) begin
					state_d = CDAC_RETRY;
				end else if (!want_play) begin
					state_d = CDAC_RDN;
				end
			end
			CDAC_RDN: begin
				if (any_fault) begin
					state_d = CDAC_RETRY;
				end else if (ramp_q == CDAC_RAMP_MIN) begin
					state_d = CDAC_OFF;
				end
			end
			CDAC_RETRY: begin
				if (!any_fault && cnt_zero && retry_en_q) begin
					state_d = CDAC_OFF;
				end
			end
			default: state_d = CDAC_OFF;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= CDAC_OFF;
		end else begin
			state_q <= state_d;
		end
	end

	// counter for calibration minimum and retry wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (state_d != state_q && state_d == CDAC_CAL) begin
			cnt_q <= CDAC_CNT_W'(CDAC_CAL_CYC);
		end else if (state_d != state_q && state_d == CDAC_RETRY) begin
			cnt_q <= CDAC_CNT_W'(CDAC_RETRY_CYC);
		end else if (state_q == CDAC_RETRY && any_fault) begin
			cnt_q <= CDAC_CNT_W'(CDAC_RETRY_CYC);
		end else if (!cnt_zero) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	logic [15:0] ramp_div_rl_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp_div_q <= 16'h0000;
			ramp_q     <= CDAC_RAMP_MIN;
		end else begin
			ramp_div_q <= ramp_tick ? ramp_div_rl_q : ramp_div_q - 16'h0001;
			if (state_q == CDAC_RUP && ramp_tick && ramp_q != CDAC_RAMP_MAX) begin
				ramp_q <= ramp_q + 1'b1;
			end else if (state_q == CDAC_RDN && ramp_tick && ramp_q != CDAC_RAMP_MIN) begin
				ramp_q <= ramp_q - 1'b1;
			end else if (state_q == CDAC_OFF || state_q == CDAC_CAL || state_q == CDAC_RETRY) begin
				ramp_q <= CDAC_RAMP_MIN;
			end
		end
	end

	wire switching = (state_q == CDAC_RUP) || (state_q == CDAC_PLAY) || (state_q == CDAC_RDN);
	wire switch_next = (state_d == CDAC_RUP) || (state_d == CDAC_PLAY) ||
		(state_d == CDAC_RDN);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bridge_q <= '0;
			oe_q     <= '0;
			gain_q   <= 2'h0;
		end else begin
			bridge_q <= switching ? pwm_in : '0;
			// follow the next state: no hi-z blip between play and ramp-down
			oe_q     <= (switch_next && !any_fault) ? 4'hF : 4'h0;
			gain_q   <= pins_s.gain_select;
		end
	end

	assign bridge_o     = bridge_q;
	assign bridge_oe    = oe_q;
	assign offset_level = ramp_q;
	assign gain_sel     = gain_q;
	assign cal_start    = (state_q == CDAC_CAL);
	assign low_power    = pins_s.sleep;
	assign bias_en      = !pins_s.sleep;
	assign status       = pins_s.sleep || any_fault;

	// interrupt events
	assign ev[CDAC_EV_FAULT]   = (state_d == CDAC_RETRY) && (state_q != CDAC_RETRY);
	assign ev[CDAC_EV_RECOVER] = (state_q == CDAC_RETRY) && (state_d == CDAC_OFF);
	assign ev[CDAC_EV_PLAY]    = (state_d == CDAC_PLAY) && (state_q != CDAC_PLAY);
	assign ev[CDAC_EV_STOP]    = (state_q == CDAC_RDN) && (state_d == CDAC_OFF);

	// apb slave, zero wait states
	wire wr_en = psel && penable && pwrite;
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction
	wire mapped = hit(paddr, CDAC_CTRL_OFS) || hit(paddr, CDAC_STATE_OFS) ||
		hit(paddr, CDAC_IRQ_ST_OFS) || hit(paddr, CDAC_IRQ_MK_OFS) ||
		hit(paddr, CDAC_RAMP_OFS);
	wire [CDAC_EV_W-1:0] w1c = (wr_en && hit(paddr, CDAC_IRQ_ST_OFS)) ?
		pwdata[CDAC_EV_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retry_en_q    <= CDAC_CTRL_RST[CDAC_CTRL_RETRY_EN];
			imask_q       <= CDAC_MASK_RST;
			ist_q         <= '0;
			ramp_div_rl_q <= CDAC_RAMP_DIV_RST;
		end else begin
			if (wr_en && hit(paddr, CDAC_CTRL_OFS)) begin
				retry_en_q <= pwdata[CDAC_CTRL_RETRY_EN];
			end
			if (wr_en && hit(paddr, CDAC_IRQ_MK_OFS)) begin
				imask_q <= pwdata[CDAC_EV_W-1:0];
			end
			if (wr_en && hit(paddr, CDAC_RAMP_OFS)) begin
				ramp_div_rl_q <= pwdata[15:0];
			end
			// set wins over clear
			ist_q <= (ist_q & ~w1c) | ev;
		end
	end

	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && hit(paddr, CDAC_CTRL_OFS)) begin
			prdata = {31'h0, retry_en_q};
		end else if (psel && hit(paddr, CDAC_STATE_OFS)) begin
			prdata = {16'h0, 3'h0, fault_q, 1'b0, state_q, status, low_power, gain_q};
		end else if (psel && hit(paddr, CDAC_IRQ_ST_OFS)) begin
			prdata = {28'h0, ist_q};
		end else if (psel && hit(paddr, CDAC_IRQ_MK_OFS)) begin
			prdata = {28'h0, imask_q};
		end else if (psel && hit(paddr, CDAC_RAMP_OFS)) begin
			prdata = {16'h0, ramp_div_rl_q};
		end
	end

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign irq     = |(ist_q & imask_q);

	a_mute_hiz: assert property (@(posedge pclk) disable iff (!presetn)
		$past(pins_s.mute) && !$past(state_d == CDAC_RDN) |-> bridge_oe == 4'h0)
		else $error("bridge driven while muted");
	a_fault_out: assert property (@(posedge pclk) disable iff (!presetn)
		any_fault |-> status ##1 bridge_oe == 4'h0)
		else $error("fault did not tri-state outputs");
	a_sleep_stat: assert property (@(posedge pclk) disable iff (!presetn)
		pins_s.sleep |-> status && low_power)
		else $error("status low in sleep");
	a_bias_mute: assert property (@(posedge pclk) disable iff (!presetn)
		pins_s.mute && !pins_s.sleep |-> bias_en)
		else $error("bias dropped in mute");
	a_cal_first: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == CDAC_RUP && $past(state_q) != CDAC_RUP |->
		$past(state_q) == CDAC_CAL && ramp_q == CDAC_RAMP_MIN)
		else $error("switching began without calibration");
	a_ramp_down: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == CDAC_OFF && $past(state_q) == CDAC_RDN |-> $past(ramp_q) == CDAC_RAMP_MIN)
		else $error("stopped before offset ramped down");
	a_auto_retry: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == CDAC_RETRY && !any_fault && retry_en_q && cnt_zero |=> state_q == CDAC_OFF)
		else $error("no recovery after fault cleared");
	a_uv_hold: assert property (@(posedge pclk) disable iff (!presetn)
		fault_q[0] && !uv_rise[0] |=> fault_q[0])
		else $error("undervoltage cleared without rising threshold");
	a_gain_map: assert property (@(posedge pclk) disable iff (!presetn)
		gain_sel == $past(pins_s.gain_select))
		else $error("gain setting mismatch");
	a_play_drive: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == CDAC_PLAY |-> bridge_oe == 4'hF)
		else $error("bridge not driven in play");
	a_sleep_stop: assert property (@(posedge pclk) disable iff (!presetn)
		pins_s.sleep |=> state_q != CDAC_PLAY)
		else $error("playing while asleep");
	a_fault_ev: assert property (@(posedge pclk) disable iff (!presetn)
		state_q != CDAC_RETRY && state_d == CDAC_RETRY |=> ist_q[CDAC_EV_FAULT])
		else $error("fault event not latched");
	a_retry_wait: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == CDAC_RETRY && any_fault |=> state_q == CDAC_RETRY)
		else $error("left retry with fault present");
	a_uv_set: assert property (@(posedge pclk) disable iff (!presetn)
		|uv_fall |=> any_fault)
		else $error("undervoltage did not raise fault");
	a_uv_clear: assert property (@(posedge pclk) disable iff (!presetn)
		uv_rise[0] && !uv_fall[0] |=> !fault_q[0])
		else $error("fault kept above rising threshold");
	a_cal_hiz: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == CDAC_CAL |-> bridge_oe == 4'h0 && cal_start)
		else $error("bridge driven during calibration");
	a_rdn_hold: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == CDAC_RDN && ramp_q != CDAC_RAMP_MIN && !any_fault
		|=> state_q == CDAC_RDN)
		else $error("switching stopped above minimum offset");
	a_off_hiz: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == CDAC_OFF && $past(state_q) == CDAC_OFF |-> bridge_oe == 4'h0)
		else $error("bridge driven while stopped");
	a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn)
		pins_s.mute != $past(pins_s.mute) |-> pins_s.mute == $past(pins.mute, 2))
		else $error("mute input not synchronised");

endmodule
`default_nettype wire

// [tb/cdac_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cdac_host_model (
	input  wire logic         supply_ok, // supplies judged stable
	input  wire logic         run,       // host wants audio
	input  wire logic         sleep_req, // host wants low power
	input  wire logic [1:0]   gain_val,  // gain wanted
	input  wire logic [1:0]   gain_drv,  // gain bits actively driven
	output var cdac_pkg::cdac_pins_t pins // pins seen by the device
);
	import cdac_pkg::*;
	// mute always driven, first up, last down
	assign pins.mute = !(supply_ok && run && !sleep_req);
	assign pins.sleep = sleep_req;
	// open gain bits fall to the pull-down level
	assign pins.gain_select = gain_val & gain_drv;
endmodule
`default_nettype wire

// [tb/class_d_amp_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
module class_d_amp_control_test;
	import cdac_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cal_done, status;
	logic bias_en, low_power, cal_start, irq, supply_ok, run, sleep_req;
	logic [7:0] paddr, offset_level;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] gain_sel, gain_val, gain_drv;
	logic er;
	cdac_pins_t pins;
	cdac_fault_t uv_fall, uv_rise;
	cdac_bridge_t pwm_in, bridge_o, bridge_oe;
	int num_errors = 0;
	int n_checks = 0;
	int m_fault;
	logic [7:0] ra [4] = '{8'h00, 8'h0C, 8'h10, 8'h20};
	logic [31:0] rv [4] = '{32'h1, 32'h0, 32'h4, 32'h0};

	cdac_host_model u_cdac_host_model (.supply_ok(supply_ok), .run(run), .sleep_req(sleep_req),
		.gain_val(gain_val), .gain_drv(gain_drv), .pins(pins));
	cdac_ctrl u_cdac_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins(pins), .uv_fall(uv_fall), .uv_rise(uv_rise),
		.cal_done(cal_done), .pwm_in(pwm_in), .bridge_o(bridge_o), .bridge_oe(bridge_oe),
		.status(status), .bias_en(bias_en), .low_power(low_power), .cal_start(cal_start),
		.offset_level(offset_level), .gain_sel(gain_sel), .irq(irq));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) pwm_in <= cdac_bridge_t'($urandom);

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic cy(input int n);
		repeat (n) @(posedge pclk);
	endtask
	function automatic logic cond(input int s);
		case (s)
			0: return cal_start === 1'b1;
			1: return offset_level === 8'hFF;
			default: return 4'(bridge_oe) === 4'h0;
		endcase
	endfunction
	task automatic wt(input int s, input int lim);
		int k;
		k = 0;
		while (!cond(s) && k < lim) begin
			@(posedge pclk);
			k++;
		end
		if (k >= lim) begin
			num_errors++;
			$display("BAD wait %0d", s);
			finish_test();
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			chk("pready", 0, 1);
			finish_test();
		end
		@(posedge pclk);
	endtask
	// expected status: sleeping or faulted
	task automatic chk_st();
		chk("status", status, 32'(sleep_req | (m_fault != 0)));
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata, cal_done, supply_ok, run} = '0;
		presetn = 1'b0;
		sleep_req = 1'b1;
		{gain_val, gain_drv} = '0;
		uv_fall = '0;
		uv_rise = '0;
		m_fault = 1;
		void'($urandom(4763));
		cy(20);
		presetn <= 1'b1;
		cy(2);
		chk_st();
		chk("oe_rst", 4'(bridge_oe), 0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, ra[i], 0);
			chk("reg", rd, rv[i]);
			chk("err", er, 32'(i == 3));
		end
		uv_rise <= '1;
		m_fault = 0;
		cy(6);
		chk_st();
		chk("lp", low_power, 1);
		sleep_req <= 1'b0;
		cy(6);
		chk_st();
		chk("bias", bias_en, 1);
		chk("oe_mute", 4'(bridge_oe), 0);
		chk("o_mute", 4'(bridge_o), 0);
		apb(1'b1, CDAC_IRQ_MK_OFS, 32'hF);
		for (int p = 0; p < 2; p++) begin
			supply_ok <= 1'b1;
			run <= 1'b1;
			wt(0, 300);
			chk("oe_cal", 4'(bridge_oe), 0);
			chk("off_cal", offset_level, 0);
			cy(210);
			cal_done <= 1'b1;
			wt(1, 3000);
			chk("oe_play", 4'(bridge_oe), 32'hF);
			chk_st();
			cal_done <= 1'b0;
			if (p == 0) begin
				cy(1);
				chk("irq", irq, 1);
				apb(1'b0, CDAC_IRQ_ST_OFS, 0);
				chk("play_ev", rd & 32'h4, 32'h4);
				apb(1'b1, CDAC_IRQ_ST_OFS, 32'hF);
				cy(1);
				chk("irq_clr", irq, 0);
				for (int g = 0; g < 4; g++) begin
					gain_val <= 2'(g);
					gain_drv <= 2'(g) | 2'($urandom);
					cy(6);
					chk("gain", gain_sel, g);
				end
				uv_rise <= '0;
				uv_fall <= cdac_fault_t'(5'h1 << ($urandom % 5));
				m_fault = 1;
				cy(6);
				chk_st();
				chk("oe_flt", 4'(bridge_oe), 0);
				chk("irq_flt", irq, 1);
				uv_fall <= '0;
				cy(150);
				chk_st();
				uv_rise <= '1;
				m_fault = 0;
			end
		end
		run <= 1'b0;
		wt(2, 3000);
		chk("off_dn", offset_level, 0);
		sleep_req <= 1'b1;
		cy(6);
		chk_st();
		finish_test();
	end
endmodule
`default_nettype wire
